// File: nvb_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "nvb_regs.vh"

module nvb_ctrl #(
    parameter integer DEPTH      = 64,
    parameter integer WR_CYCLES  = `NVB_WR_TIME_NS / `NVB_CLK_NS
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       sfr_bank,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    output wire       nv_busy
);

    // ==========================================================
    // state codes and timer loads
    localparam [1:0]  ST_IDLE  = 2'd0;
    localparam [1:0]  ST_WRITE = 2'd1;
    localparam [1:0]  ST_READ  = 2'd2;

    localparam [15:0] TMR_WR   = WR_CYCLES[15:0];
    localparam [15:0] TMR_RD   = `NVB_RD_CYCLES;
    localparam [15:0] TMR_ONE  = 16'h0001;
    localparam [15:0] TMR_ZERO = 16'h0000;

    // ==========================================================
    // storage and registers
    reg  [7:0]  mem [0:DEPTH-1];

    reg  [5:0]  nv_address_reg_r;
    reg  [5:0]  nv_address_reg_nxt;
    reg  [7:0]  nv_data_reg_r;
    reg  [7:0]  nv_data_reg_nxt;

    reg         wr_permit_r;
    reg         wr_permit_nxt;
    reg         rd_permit_r;
    reg         rd_permit_nxt;
    reg         wr_trig_r;
    reg         wr_trig_nxt;
    reg         rd_trig_r;
    reg         rd_trig_nxt;

    reg  [15:0] tmr_r;
    reg  [15:0] tmr_nxt;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;

    reg  [7:0]  sfr_rdata_nxt;
    reg  [3:0]  nv_control_reg;

    // ==========================================================
    // decode helpers
    // true when the access names this bank and offset
    function sel;
        input       bank;
        input [7:0] ofs;
        begin
            sel = (sfr_bank == bank) && (sfr_addr == ofs);
        end
    endfunction

    function hit;
        input       bank;
        input [7:0] ofs;
        begin
            hit = sfr_wr && sel(bank, ofs);
        end
    endfunction

    wire        wr_a;
    wire        wr_d;
    wire        wr_c;
    wire        busy_w;
    wire        go_w;
    wire        go_r;
    wire        tmr_last;
    wire        wr_done;
    wire        rd_done;
    wire [7:0]  mem_rd;

    assign wr_a = hit(`NVB_ADDR_BANK, `NVB_ADDR_OFS);
    assign wr_d = hit(`NVB_DATA_BANK, `NVB_DATA_OFS);
    assign wr_c = hit(`NVB_CTRL_BANK, `NVB_CTRL_OFS);

    assign busy_w = (state_r != ST_IDLE);

    // trigger honoured only if permit already held before this write
    assign go_w = wr_c && sfr_wdata[`NVB_WR_TRIG_BIT] && wr_permit_r
                  && !busy_w;
    // write wins when both triggers arrive together
    assign go_r = wr_c && sfr_wdata[`NVB_RD_TRIG_BIT] && rd_permit_r
                  && !busy_w && !go_w;

    assign tmr_last = (tmr_r == TMR_ONE);
    assign wr_done  = (state_r == ST_WRITE) && tmr_last;
    assign rd_done  = (state_r == ST_READ) && tmr_last;
    assign mem_rd   = mem[nv_address_reg_r];

    assign nv_busy  = busy_w;

    // ==========================================================
    // address register next value
    always @* begin
        nv_address_reg_nxt = nv_address_reg_r;
        if (wr_a && !busy_w) begin
            nv_address_reg_nxt = sfr_wdata[5:0];
        end
    end

    // ==========================================================
    // data register next value
    always @* begin
        nv_data_reg_nxt = nv_data_reg_r;
        if (rd_done) begin
            nv_data_reg_nxt = mem_rd;
        end else if (wr_d && !busy_w) begin
            nv_data_reg_nxt = sfr_wdata;
        end
    end

    // ==========================================================
    // permit bits, plain read/write
    always @* begin
        wr_permit_nxt = wr_permit_r;
        rd_permit_nxt = rd_permit_r;
        if (wr_c) begin
            wr_permit_nxt = sfr_wdata[`NVB_WR_PERMIT_BIT];
            rd_permit_nxt = sfr_wdata[`NVB_RD_PERMIT_BIT];
        end
    end

    // ==========================================================
    // trigger bits, set by software, cleared by hardware
    // writing a zero trigger never aborts a running cycle
    always @* begin
        wr_trig_nxt = wr_trig_r;
        rd_trig_nxt = rd_trig_r;
        if (go_w) begin
            wr_trig_nxt = 1'b1;
        end else if (wr_done) begin
            wr_trig_nxt = 1'b0;
        end
        if (go_r) begin
            rd_trig_nxt = 1'b1;
        end else if (rd_done) begin
            rd_trig_nxt = 1'b0;
        end
    end

    // ==========================================================
    // cycle timer
    always @* begin
        tmr_nxt = tmr_r;
        if (go_w) begin
            tmr_nxt = TMR_WR;
        end else if (go_r) begin
            tmr_nxt = TMR_RD;
        end else if (tmr_r != TMR_ZERO) begin
            tmr_nxt = tmr_r - TMR_ONE;
        end
    end

    // ==========================================================
    // sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go_w) begin
                    state_nxt = ST_WRITE;
                end else if (go_r) begin
                    state_nxt = ST_READ;
                end
            end
            ST_WRITE: begin
                if (tmr_last) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_READ: begin
                if (tmr_last) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // control register image
    always @* begin
        nv_control_reg = `NVB_CTRL_RST;
        nv_control_reg[`NVB_WR_PERMIT_BIT] = wr_permit_r;
        nv_control_reg[`NVB_WR_TRIG_BIT]   = wr_trig_r;
        nv_control_reg[`NVB_RD_PERMIT_BIT] = rd_permit_r;
        nv_control_reg[`NVB_RD_TRIG_BIT]   = rd_trig_r;
    end

    // ==========================================================
    // read mux
    always @* begin
        sfr_rdata_nxt = 8'h00;
        if (sel(`NVB_ADDR_BANK, `NVB_ADDR_OFS)) begin
            sfr_rdata_nxt = {2'b00, nv_address_reg_r};
        end else if (sel(`NVB_DATA_BANK, `NVB_DATA_OFS)) begin
            sfr_rdata_nxt = nv_data_reg_r;
        end else if (sel(`NVB_CTRL_BANK, `NVB_CTRL_OFS)) begin
            sfr_rdata_nxt = {4'h0, nv_control_reg};
        end
    end

    // ==========================================================
    // storage array, not reset: contents survive reset
    always @(posedge clk) begin
        if (wr_done) begin
            mem[nv_address_reg_r] <= nv_data_reg_r;
        end
    end

    // ==========================================================
    // registers
    always @(posedge clk) begin
        if (!rst_n) begin
            nv_address_reg_r <= `NVB_ADDR_RST;
            nv_data_reg_r    <= `NVB_DATA_RST;
            wr_permit_r      <= 1'b0;
            rd_permit_r      <= 1'b0;
            wr_trig_r        <= 1'b0;
            rd_trig_r        <= 1'b0;
            tmr_r            <= TMR_ZERO;
            state_r          <= ST_IDLE;
            sfr_rdata        <= 8'h00;
        end else begin
            nv_address_reg_r <= nv_address_reg_nxt;
            nv_data_reg_r    <= nv_data_reg_nxt;
            wr_permit_r      <= wr_permit_nxt;
            rd_permit_r      <= rd_permit_nxt;
            wr_trig_r        <= wr_trig_nxt;
            rd_trig_r        <= rd_trig_nxt;
            tmr_r            <= tmr_nxt;
            state_r          <= state_nxt;
            sfr_rdata        <= sfr_rdata_nxt;
        end
    end

endmodule // nvb_ctrl
`default_nettype wire

// File: nvb_regs.vh
`ifndef NVB_REGS_VH
`define NVB_REGS_VH
// special-register addresses as seen by the core
`define NVB_ADDR_BANK       1'b0
`define NVB_ADDR_OFS        8'h00
`define NVB_DATA_BANK       1'b0
`define NVB_DATA_OFS        8'h01
`define NVB_CTRL_BANK       1'b1
`define NVB_CTRL_OFS        8'h40
// control field positions
`define NVB_RD_TRIG_BIT     0
`define NVB_RD_PERMIT_BIT   1
`define NVB_WR_TRIG_BIT     2
`define NVB_WR_PERMIT_BIT   3
// reset values
`define NVB_ADDR_RST        6'h00
`define NVB_DATA_RST        8'h00
`define NVB_CTRL_RST        4'h0
// timing
`define NVB_WR_TIME_NS      4000
`define NVB_CLK_NS          20
`define NVB_RD_CYCLES       16'd2
`endif

// File: nvb_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module nvb_ctrl_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sfr_bank,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       nv_busy
);
    // ========================================
    // permit shadow
    logic wp_r;
    logic rp_r;
    logic cw;
    logic cw_idle;
    assign cw = sfr_wr && sfr_bank && sfr_addr == 8'h40;
    assign cw_idle = cw && !nv_busy;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
        end else if (cw) begin
            wp_r <= sfr_wdata[3];
            rp_r <= sfr_wdata[1];
        end
    end
    // ========================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_write_length: assert property (
        cw_idle && wp_r && sfr_wdata[2] |=> nv_busy [*4] ##1 !nv_busy)
        else $error("write length");
    chk_write_refused: assert property (
        cw_idle && !wp_r && sfr_wdata[2] && !(rp_r && sfr_wdata[0]) |=> !nv_busy)
        else $error("write not refused");
    chk_read_length: assert property (
        cw_idle && rp_r && sfr_wdata[0] && !sfr_wdata[2] |=> nv_busy [*2] ##1 !nv_busy)
        else $error("read length");
    chk_read_refused: assert property (
        cw_idle && !rp_r && sfr_wdata[0] && !(wp_r && sfr_wdata[2]) |=> !nv_busy)
        else $error("read not refused");
    chk_ctrl_upper: assert property (
        sfr_bank && sfr_addr == 8'h40 |=> sfr_rdata[7:4] == 4'h0) else $error("ctrl upper");
    chk_addr_upper: assert property (
        !sfr_bank && sfr_addr == 8'h00 |=> sfr_rdata[7:6] == 2'h0) else $error("addr upper");
    chk_trig_poll: assert property (
        sfr_bank && sfr_addr == 8'h40 |=> (sfr_rdata[2] | sfr_rdata[0]) == $past(nv_busy))
        else $error("trigger poll");
    chk_unmapped_zero: assert property (
        !sfr_bank && sfr_addr == 8'h10 |=> sfr_rdata == 8'h00) else $error("unmapped");
endmodule // nvb_ctrl_assertions
bind nvb_ctrl nvb_ctrl_assertions u_chk (.clk(clk), .rst_n(rst_n), .sfr_bank(sfr_bank),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .nv_busy(nv_busy));
`default_nettype wire

// File: nvb_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module nvb_ctrl_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       sfr_bank = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    wire  [7:0] sfr_rdata;
    wire        nv_busy;
    int         n_fail = 0;
    int         checks_done = 0;
    int         cyc = 0;
    nvb_ctrl #(.WR_CYCLES(4)) u_nvb_ctrl (.clk(clk), .rst_n(rst_n), .sfr_bank(sfr_bank),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .nv_busy(nv_busy));
    // ========================================
    // bus tasks
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        {sfr_wr, sfr_bank, sfr_addr, sfr_wdata} = {1'b1, b, a, d};
        @(posedge clk);
        #1;
    endtask
    task automatic rc(input logic b, input logic [7:0] a, input logic [7:0] e);
        {sfr_wr, sfr_bank, sfr_addr} = {1'b0, b, a};
        @(posedge clk);
        #1;
        chk(sfr_rdata, e);
    endtask
    task automatic idle;
        for (int i = 0; i < 20 && (sfr_rdata & 8'h05) !== 8'h00; i++) begin
            {sfr_wr, sfr_bank, sfr_addr} = {1'b0, 1'b1, 8'h40};
            @(posedge clk);
            #1;
        end
    endtask
    // ========================================
    // scenarios
    task automatic t_reset;
        rc(1'b0, 8'h00, 8'h00);
        rc(1'b0, 8'h01, 8'h00);
        rc(1'b1, 8'h40, 8'h00);
        rc(1'b0, 8'h10, 8'h00);
    endtask
    task automatic t_refuse;
        wr(1'b1, 8'h40, 8'h04);
        chk({7'h00, nv_busy}, 8'h00);
        rc(1'b1, 8'h40, 8'h00);
        wr(1'b1, 8'h40, 8'h01);
        rc(1'b1, 8'h40, 8'h00);
        wr(1'b0, 8'h00, 8'hFF);
        rc(1'b0, 8'h00, 8'h3F);
    endtask
    task automatic t_move;
        wr(1'b0, 8'h01, 8'hA5);
        wr(1'b1, 8'h40, 8'h08);
        wr(1'b1, 8'h40, 8'h0C);
        rc(1'b1, 8'h40, 8'h0C);
        chk({7'h00, nv_busy}, 8'h01);
        wr(1'b0, 8'h01, 8'h5A);
        rc(1'b0, 8'h01, 8'hA5);
        idle;
        chk({7'h00, nv_busy}, 8'h00);
        rc(1'b1, 8'h40, 8'h08);
        wr(1'b0, 8'h01, 8'h00);
        wr(1'b1, 8'h40, 8'h02);
        wr(1'b1, 8'h40, 8'h03);
        rc(1'b1, 8'h40, 8'h03);
        chk({7'h00, nv_busy}, 8'h01);
        idle;
        rc(1'b0, 8'h01, 8'hA5);
        wr(1'b0, 8'h00, 8'h00);
        rc(1'b0, 8'h01, 8'hA5);
    endtask
    task automatic test_done;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 500) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset;
        t_refuse;
        t_move;
        test_done;
    end
endmodule // nvb_ctrl_bench
`default_nettype wire
